// ===== design/scc_cfg.svh
// Constants of the system clock controller: offsets, fields, reset values, timing.
// Assumes inclusion by the design modules and the bench, by bare name.
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

`define SCC_AW 4
`define SCC_DW 8

`define SCC_OFF_SRC_REQ 4'h0
`define SCC_OFF_SRC_CUR 4'h1
`define SCC_OFF_DIV 4'h2
`define SCC_OFF_GATE1 4'h3
`define SCC_OFF_GATE2 4'h4
`define SCC_OFF_TRIM 4'h5
`define SCC_OFF_CLKOUT 4'h6
`define SCC_OFF_CORE 4'h7
`define SCC_OFF_IRQ_STAT 4'h8
`define SCC_OFF_IRQ_MASK 4'h9
`define SCC_OFF_MON_CTRL 4'hA

`define SCC_GATE1_MASK 8'hFB
`define SCC_GATE2_MASK 8'h0C
`define SCC_GATE_RST 8'hFF
`define SCC_DIV_BY8 2'h3
`define SCC_TRIM_SIGN 3
`define SCC_TRIM_COMPAT_MASK 3'h3
`define SCC_TRIM_FULL_MASK 3'h7

`define SCC_CLKOUT_EN 0
`define SCC_CLKOUT_SEL_HI 2
`define SCC_CLKOUT_SEL_LO 1
`define SCC_CORE_STOP 0
`define SCC_IRQ_FAIL 0
`define SCC_IRQ_SWDONE 1
`define SCC_IRQ_W 2
`define SCC_MON_EN 0

`define SCC_OPT_COMPAT_BIT 0
`define SCC_OPT_SLOW_OK_BIT 3

`define SCC_CLK_PERIOD_NS 5
`define SCC_WAKE_STAB_NS 1000
`define SCC_WAKE_STAB_CYC ((`SCC_WAKE_STAB_NS + `SCC_CLK_PERIOD_NS - 1) / `SCC_CLK_PERIOD_NS)
`define SCC_MON_GAP_NS 2000
`define SCC_MON_GAP_CYC (`SCC_MON_GAP_NS / `SCC_CLK_PERIOD_NS)
`define SCC_CNT_W 10

`endif

// ===== design/scc_pkg.sv
// Types shared by the system clock controller modules.
// Takes no numeric constants from scc_cfg.svh; enum widths are written out here.
package scc_pkg;
   typedef enum logic [1:0] {SRC_FAST_RC, SRC_SLOW_RC, SRC_XTAL, SRC_EXT_IN} scc_src_t;
   typedef enum logic {SW_RUN, SW_BREAK} scc_sw_state_t;
   typedef enum logic [1:0] {WK_RUN, WK_HALT, WK_STAB} scc_wk_state_t;
endpackage : scc_pkg

// ===== design/scc_switch.sv
// Break-before-make source switch for the system clock.
// Assumes ready flags synchronous to ref_clk_i.
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_switch (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Request
   input wire scc_pkg::scc_src_t target_i,
   input wire logic [3:0] ready_i,
   // Result
   output scc_pkg::scc_src_t cur_o,
   output logic [3:0] src_en_o,
   output logic done_o
);
   import scc_pkg::*;

   scc_sw_state_t state_reg, state_next;
   scc_src_t cur_reg, cur_next;
   scc_src_t pend_reg, pend_next;
   logic [3:0] en_reg, en_next;
   logic done_reg;
   wire want_switch = (target_i != cur_reg) && ready_i[target_i];

   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      pend_next = pend_reg;
      en_next = en_reg;
      unique case (state_reg)
         SW_RUN: begin
            // Old source stays until the new one is ready
            if (want_switch) begin
               state_next = SW_BREAK;
               pend_next = target_i;
               en_next = 4'h0;
            end
         end
         SW_BREAK: begin
            state_next = SW_RUN;
            cur_next = pend_reg;
            en_next = 4'h1 << pend_reg;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= SW_RUN;
         cur_reg <= SRC_FAST_RC;
         pend_reg <= SRC_FAST_RC;
         en_reg <= 4'h1;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         pend_reg <= pend_next;
         en_reg <= en_next;
         done_reg <= (state_reg == SW_BREAK);
      end
   end

   assign cur_o = cur_reg;
   assign src_en_o = en_reg;
   assign done_o = done_reg;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_break_gap: assert property (state_reg == SW_RUN && want_switch |=> src_en_o == 4'h0 ##1 $onehot(src_en_o))
      else $error("switch did not break before make");
   a_wait_ready: assert property ($changed(cur_reg) |-> $past(ready_i[target_i], 2))
      else $error("switched to a source that was not ready");
endmodule : scc_switch

// ===== design/scc_fail_mon.sv
// Missing-edge monitor for the external clock source.
// Assumes the external level is sampled synchronously to ref_clk_i.
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_fail_mon (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Watch
   input wire logic enable_i,
   input wire logic ext_lvl_i,
   // Event
   output logic fail_o
);
   logic prev_reg;
   logic fired_reg;
   logic fail_reg;
   logic [`SCC_CNT_W-1:0] gap_reg;
   wire edge_seen = ext_lvl_i != prev_reg;
   wire gap_full = gap_reg == `SCC_CNT_W'(`SCC_MON_GAP_CYC - 1);

   // One event per watch period; avoids a storm while the switch completes
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev_reg <= 1'b0;
         fired_reg <= 1'b0;
         fail_reg <= 1'b0;
         gap_reg <= '0;
      end else begin
         prev_reg <= ext_lvl_i;
         fail_reg <= enable_i && !fired_reg && gap_full && !edge_seen;
         fired_reg <= enable_i && (fired_reg || (gap_full && !edge_seen));
         gap_reg <= (!enable_i || edge_seen || gap_full) ? '0 : gap_reg + 1'b1;
      end
   end

   assign fail_o = fail_reg;

   a_fail_needs_en: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      fail_o |-> $past(enable_i))
      else $error("failure reported while monitor disabled");
endmodule : scc_fail_mon

// ===== design/scc_clock_ctrl.sv
// System clock controller: source selection, division, gating, wakeup,
// failure monitor, trim, clock output and its register port.
// Assumes oscillator ready flags and sampled source levels synchronous to ref_clk_i.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "scc_cfg.svh"
module scc_clock_ctrl (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [`SCC_AW-1:0] reg_addr_i,
   input wire logic [`SCC_DW-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [`SCC_DW-1:0] reg_rdata_o,
   // Oscillators
   input wire logic [3:0] src_ready_i,
   input wire logic [3:0] src_lvl_i,
   input wire logic [7:0] factory_trim_i,
   // Option byte pair
   input wire logic [7:0] option_byte_three_i,
   input wire logic [7:0] option_byte_three_inverse_i,
   // Power mode
   input wire logic halt_i,
   // Clock controls
   output scc_pkg::scc_src_t sys_src_o,
   output logic [3:0] src_en_o,
   output logic [1:0] sys_div_o,
   output logic core_clk_en_o,
   output logic [15:0] periph_clk_en_o,
   output logic slow_rc_en_o,
   output logic clock_output_o,
   output logic [7:0] rc_trim_o,
   // Interrupt
   output logic irq_o
);
   import scc_pkg::*;

   scc_src_t src_req_reg, src_req_next;
   scc_src_t saved_src_reg;
   scc_src_t cur_src;
   scc_wk_state_t wk_reg, wk_next;
   logic [1:0] div_reg, div_next;
   logic [1:0] saved_div_reg;
   logic [7:0] gate1_reg;
   logic [7:0] gate2_reg;
   logic [3:0] trim_reg;
   logic [2:0] clkout_reg;
   logic core_stop_reg;
   logic [`SCC_IRQ_W-1:0] stat_reg;
   logic [`SCC_IRQ_W-1:0] mask_reg;
   logic mon_en_reg;
   logic [`SCC_CNT_W-1:0] stab_reg;
   logic [`SCC_DW-1:0] rdata_reg;
   logic clkout_reg_q;
   logic [7:0] trim_out_reg;
   logic sw_done;
   logic mon_fail;

   // Address decode
   wire wr_req = reg_wr_i && reg_addr_i == `SCC_OFF_SRC_REQ;
   wire wr_div = reg_wr_i && reg_addr_i == `SCC_OFF_DIV;
   wire wr_g1 = reg_wr_i && reg_addr_i == `SCC_OFF_GATE1;
   wire wr_g2 = reg_wr_i && reg_addr_i == `SCC_OFF_GATE2;
   wire wr_trim = reg_wr_i && reg_addr_i == `SCC_OFF_TRIM;
   wire wr_cko = reg_wr_i && reg_addr_i == `SCC_OFF_CLKOUT;
   wire wr_core = reg_wr_i && reg_addr_i == `SCC_OFF_CORE;
   wire wr_stat = reg_wr_i && reg_addr_i == `SCC_OFF_IRQ_STAT;
   wire wr_mask = reg_wr_i && reg_addr_i == `SCC_OFF_IRQ_MASK;
   wire wr_mon = reg_wr_i && reg_addr_i == `SCC_OFF_MON_CTRL;

   // Option pair is only honoured when the two bytes are complementary
   wire opt_valid = option_byte_three_i == ~option_byte_three_inverse_i;
   wire compat_trim_select = opt_valid && option_byte_three_i[`SCC_OPT_COMPAT_BIT];
   wire slow_rc_sysclk_allow = opt_valid && option_byte_three_i[`SCC_OPT_SLOW_OK_BIT];
   wire scc_src_t wr_src = scc_src_t'(reg_wdata_i[1:0]);
   wire req_ok = (wr_src != SRC_SLOW_RC) || slow_rc_sysclk_allow;
   wire ext_in_use = (cur_src == SRC_XTAL) || (cur_src == SRC_EXT_IN);
   wire in_wake = wk_reg != WK_RUN;
   wire stab_done = stab_reg == `SCC_CNT_W'(`SCC_WAKE_STAB_CYC - 1);
   wire [`SCC_IRQ_W-1:0] events = {sw_done, mon_fail};

   // Requested source and divider, with wakeup and failure overrides
   always_comb begin
      wk_next = wk_reg;
      src_req_next = src_req_reg;
      div_next = div_reg;
      if (wr_req && req_ok && !in_wake)
         src_req_next = wr_src;
      if (wr_div && !in_wake)
         div_next = reg_wdata_i[1:0];
      unique case (wk_reg)
         WK_RUN: begin
            if (halt_i)
               wk_next = WK_HALT;
         end
         WK_HALT: begin
            if (!halt_i) begin
               wk_next = WK_STAB;
               src_req_next = SRC_FAST_RC;
               div_next = `SCC_DIV_BY8;
            end
         end
         WK_STAB: begin
            if (stab_done) begin
               wk_next = WK_RUN;
               src_req_next = saved_src_reg;
               div_next = saved_div_reg;
            end
         end
         default: wk_next = WK_RUN;
      endcase
      if (mon_fail) begin
         src_req_next = SRC_FAST_RC;
         div_next = `SCC_DIV_BY8;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wk_reg <= WK_RUN;
         src_req_reg <= SRC_FAST_RC;
         div_reg <= `SCC_DIV_BY8;
         saved_src_reg <= SRC_FAST_RC;
         saved_div_reg <= `SCC_DIV_BY8;
         stab_reg <= '0;
      end else begin
         wk_reg <= wk_next;
         src_req_reg <= src_req_next;
         div_reg <= div_next;
         // Restarts on every stabilisation; the restore fires on its last count
         stab_reg <= (wk_reg == WK_STAB) ? stab_reg + 1'b1 : '0;
         if (wk_reg == WK_RUN && halt_i) begin
            saved_src_reg <= src_req_reg;
            saved_div_reg <= div_reg;
         end
      end
   end

   // Software settings
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gate1_reg <= `SCC_GATE_RST & `SCC_GATE1_MASK;
         gate2_reg <= `SCC_GATE_RST & `SCC_GATE2_MASK;
         trim_reg <= 4'h0;
         clkout_reg <= 3'h0;
         core_stop_reg <= 1'b0;
         mask_reg <= '0;
         mon_en_reg <= 1'b0;
      end else begin
         if (wr_g1)
            gate1_reg <= reg_wdata_i & `SCC_GATE1_MASK;
         if (wr_g2)
            gate2_reg <= reg_wdata_i & `SCC_GATE2_MASK;
         if (wr_trim)
            trim_reg <= reg_wdata_i[3:0];
         if (wr_cko)
            clkout_reg <= reg_wdata_i[2:0];
         if (wr_core)
            core_stop_reg <= reg_wdata_i[`SCC_CORE_STOP];
         if (wr_mask)
            mask_reg <= reg_wdata_i[`SCC_IRQ_W-1:0];
         if (wr_mon)
            mon_en_reg <= reg_wdata_i[`SCC_MON_EN];
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         stat_reg <= '0;
      else
         stat_reg <= (stat_reg & ~(wr_stat ? reg_wdata_i[`SCC_IRQ_W-1:0] : '0)) | events;
   end

   assign irq_o = |(stat_reg & mask_reg);

   // Trim adjust: sign and magnitude added on top of factory value
   wire [2:0] trim_mag = trim_reg[2:0] & (compat_trim_select ? `SCC_TRIM_COMPAT_MASK : `SCC_TRIM_FULL_MASK);
   wire [7:0] trim_sum = trim_reg[`SCC_TRIM_SIGN] ? factory_trim_i - {5'h0, trim_mag}
                                                  : factory_trim_i + {5'h0, trim_mag};
   // Clock output follows the sampled level of the chosen source
   wire cko_lvl = src_lvl_i[clkout_reg[`SCC_CLKOUT_SEL_HI:`SCC_CLKOUT_SEL_LO]];

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         trim_out_reg <= 8'h00;
         clkout_reg_q <= 1'b0;
      end else begin
         trim_out_reg <= trim_sum;
         clkout_reg_q <= clkout_reg[`SCC_CLKOUT_EN] && cko_lvl;
      end
   end

   // Read path, data valid the cycle after the strobe
   logic [`SCC_DW-1:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr_i)
         `SCC_OFF_SRC_REQ: rd_mux = {6'h00, src_req_reg};
         `SCC_OFF_SRC_CUR: rd_mux = {6'h00, cur_src};
         `SCC_OFF_DIV: rd_mux = {6'h00, div_reg};
         `SCC_OFF_GATE1: rd_mux = gate1_reg;
         `SCC_OFF_GATE2: rd_mux = gate2_reg;
         `SCC_OFF_TRIM: rd_mux = {4'h0, trim_reg};
         `SCC_OFF_CLKOUT: rd_mux = {5'h00, clkout_reg};
         `SCC_OFF_CORE: rd_mux = {7'h00, core_stop_reg};
         `SCC_OFF_IRQ_STAT: rd_mux = {6'h00, stat_reg};
         `SCC_OFF_IRQ_MASK: rd_mux = {6'h00, mask_reg};
         `SCC_OFF_MON_CTRL: rd_mux = {7'h00, mon_en_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
   end

   scc_switch u_switch (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .target_i(src_req_reg),
      .ready_i(src_ready_i),
      .cur_o(cur_src),
      .src_en_o(src_en_o),
      .done_o(sw_done)
   );

   scc_fail_mon u_fail_mon (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .enable_i(mon_en_reg && ext_in_use),
      .ext_lvl_i(src_lvl_i[cur_src]),
      .fail_o(mon_fail)
   );

   // Peripheral clock enables, one per gate bit
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_gate
         assign periph_clk_en_o[gi] = gate1_reg[gi];
         assign periph_clk_en_o[gi+8] = gate2_reg[gi];
      end
   endgenerate

   assign reg_rdata_o = rdata_reg;
   assign sys_src_o = cur_src;
   assign sys_div_o = div_reg;
   assign core_clk_en_o = !core_stop_reg && wk_reg != WK_HALT;
   // Slow RC never stops: watchdog and wakeup timer depend on it
   assign slow_rc_en_o = 1'b1;
   assign clock_output_o = clkout_reg_q;
   assign rc_trim_o = trim_out_reg;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   a_fail_forces_rc: assert property (mon_fail |=> src_req_reg == SRC_FAST_RC && div_reg == `SCC_DIV_BY8)
      else $error("failure did not force fast RC divided by eight");
   a_fail_flag_sticky: assert property (stat_reg[`SCC_IRQ_FAIL] && !wr_stat |=> stat_reg[`SCC_IRQ_FAIL])
      else $error("failure flag dropped without a clear");
   a_slow_refused: assert property (wr_req && wr_src == SRC_SLOW_RC && !slow_rc_sysclk_allow
      && src_req_reg != SRC_SLOW_RC && !in_wake |=> src_req_reg != SRC_SLOW_RC)
      else $error("slow RC accepted without option");
   a_reserved_zero: assert property (!(gate1_reg[2]) && gate2_reg[7:4] == 4'h0 && gate2_reg[1:0] == 2'h0)
      else $error("reserved gate bit set");
   a_wake_fast_rc: assert property (wk_reg == WK_HALT && !halt_i |=> src_req_reg == SRC_FAST_RC
      && div_reg == `SCC_DIV_BY8 && wk_reg == WK_STAB)
      else $error("wakeup not on fast RC divided by eight");
   a_wake_restore: assert property (wk_reg == WK_STAB && stab_done && !mon_fail |=>
      src_req_reg == saved_src_reg && wk_reg == WK_RUN)
      else $error("wakeup did not restore source");
   a_trim_compat: assert property (compat_trim_select && !trim_reg[`SCC_TRIM_SIGN] |=>
      rc_trim_o == factory_trim_i + {6'h00, $past(trim_reg[1:0])} || $changed(factory_trim_i))
      else $error("compat trim used upper magnitude bit");
   a_gate_follow: assert property (wr_g1 |=> periph_clk_en_o[7:0] == ($past(reg_wdata_i) & `SCC_GATE1_MASK))
      else $error("gate write not applied");
   a_core_stop: assert property (core_stop_reg |-> !core_clk_en_o)
      else $error("core clock running while stopped");
   a_gate2_follow: assert property (wr_g2 |=>
      periph_clk_en_o[15:8] == ($past(reg_wdata_i) & `SCC_GATE2_MASK))
      else $error("second gate write not applied");
   a_trim_full: assert property (!compat_trim_select && !trim_reg[`SCC_TRIM_SIGN] |=>
      rc_trim_o == factory_trim_i + {5'h00, $past(trim_reg[2:0])} || $changed(factory_trim_i))
      else $error("full trim not applied");
   a_fail_sets_flag: assert property (mon_fail |=> stat_reg[`SCC_IRQ_FAIL])
      else $error("failure did not set its status flag");
   a_fail_once: assert property (mon_fail |=> !mon_fail)
      else $error("failure reported twice in a row");
   a_done_flag: assert property (sw_done |=> stat_reg[`SCC_IRQ_SWDONE])
      else $error("finished switch not flagged");
   a_cko_off: assert property (!clkout_reg[`SCC_CLKOUT_EN] |=> !clock_output_o)
      else $error("clock output toggling while disabled");
   a_en_matches_src: assert property (src_en_o == 4'h0 || src_en_o == (4'h1 << sys_src_o))
      else $error("source enable does not match current source");

   c_switch_xtal: cover property (sw_done && cur_src == SRC_XTAL);
   c_fail_event: cover property (mon_fail ##1 irq_o);
   c_wake_cycle: cover property (wk_reg == WK_STAB ##1 wk_reg == WK_RUN);
   c_slow_sysclk: cover property (sw_done && cur_src == SRC_SLOW_RC);
   c_halt_entry: cover property (wk_reg == WK_RUN && halt_i ##1 !core_clk_en_o);
endmodule : scc_clock_ctrl

// ===== bench/scc_osc_model.sv
// Oscillator bank model: ready flags and sampled levels of the four sources.
// Assumes the bench gates readiness and running per source; a stopped source holds its level.
`timescale 1ns/1ps
module scc_osc_model (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Control from bench
   input wire logic [3:0] ready_req_i,
   input wire logic [3:0] run_i,
   // Towards the controller
   output logic [3:0] src_ready_o,
   output logic [3:0] src_lvl_o
);
   logic [3:0] div_reg;
   assign src_ready_o = ready_req_i;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         div_reg <= 4'h0;
         src_lvl_o <= 4'h0;
      end else begin
         div_reg <= div_reg + 4'h1;
         if (run_i[0]) src_lvl_o[0] <= ~src_lvl_o[0];
         // Free running, unrelated to the selected source
         if (run_i[1] && div_reg[2:0] == 3'h7) src_lvl_o[1] <= ~src_lvl_o[1];
         if (run_i[2] && div_reg[0]) src_lvl_o[2] <= ~src_lvl_o[2];
         // Outside party clock into the oscillator input
         if (run_i[3] && div_reg[1:0] == 2'h3) src_lvl_o[3] <= ~src_lvl_o[3];
      end
   end
endmodule : scc_osc_model

// ===== bench/test_scc_clock_ctrl.sv
// Self-checking bench for the system clock controller.
// Assumes the oscillator model supplies ready flags and source levels.
`timescale 1ns/1ps
`include "scc_cfg.svh"
module test_scc_clock_ctrl;
   import scc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [3:0] src_ready_i;
   logic [3:0] src_lvl_i;
   logic [7:0] factory_trim_i = 8'h40;
   logic [7:0] opt_byte = 8'h00;
   logic [7:0] opt_inv = 8'hFF;
   logic halt_i = 1'b0;
   logic [3:0] ready_req = 4'h3;
   logic [3:0] run_en = 4'hF;
   scc_src_t sys_src_o;
   logic [3:0] src_en_o;
   logic [1:0] sys_div_o;
   logic core_clk_en_o;
   logic [15:0] periph_clk_en_o;
   logic slow_rc_en_o;
   logic clock_output_o;
   logic [7:0] rc_trim_o;
   logic irq_o;
   logic [7:0] rd_data;
   int n_errors = 0;
   int checks_done = 0;

   always #2.5 ref_clk_i = ~ref_clk_i;

   scc_osc_model u_osc (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ready_req_i(ready_req),
      .run_i(run_en), .src_ready_o(src_ready_i), .src_lvl_o(src_lvl_i));

   scc_clock_ctrl u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .src_ready_i(src_ready_i), .src_lvl_i(src_lvl_i), .factory_trim_i(factory_trim_i),
      .option_byte_three_i(opt_byte), .option_byte_three_inverse_i(opt_inv), .halt_i(halt_i),
      .sys_src_o(sys_src_o), .src_en_o(src_en_o), .sys_div_o(sys_div_o), .core_clk_en_o(core_clk_en_o),
      .periph_clk_en_o(periph_clk_en_o), .slow_rc_en_o(slow_rc_en_o), .clock_output_o(clock_output_o),
      .rc_trim_o(rc_trim_o), .irq_o(irq_o));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      rd_data = reg_rdata_o;
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc

   // Bounded wait; a hang shows up as a mismatch, not a stall
   task automatic wait_src(input scc_src_t s);
      int i;
      i = 0;
      while (sys_src_o !== s && i < 600) begin
         cyc(1);
         i++;
      end
      chk("sys_src_o", 16'(s), 16'(sys_src_o));
   endtask : wait_src

   task automatic count_out(input int exp);
      int n;
      logic prev;
      n = 0;
      prev = clock_output_o;
      repeat (16) begin
         cyc(1);
         if (clock_output_o !== prev) n++;
         prev = clock_output_o;
      end
      chk("clock_output_o edges", 16'(exp), 16'(n));
   endtask : count_out

   task automatic end_sim;
      $display("Checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // More than one source enabled at once would mean a make-before-break overlap
   always @(posedge ref_clk_i) begin
      if (resetn_i && $countones(src_en_o) > 1) chk("src_en_o onehot", 16'h0000, 16'h0001);
   end

   initial begin
      #60000;
      n_errors++;
      end_sim();
   end

   initial begin
      cyc(12);
      @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      cyc(2);
      chk("sys_src_o", 16'h0000, 16'(sys_src_o));
      chk("sys_div_o", 16'h0003, 16'(sys_div_o));
      chk("src_en_o", 16'h0001, 16'(src_en_o));
      chk("periph_clk_en_o", 16'h0CFB, periph_clk_en_o);
      chk("slow_rc_en_o", 16'h0001, 16'(slow_rc_en_o));
      rd(4'h2);
      chk("div reg", 16'h0003, 16'(rd_data));
      wr(4'h3, 8'hFF);
      rd(4'h3);
      chk("gate1 reg", 16'h00FB, 16'(rd_data));
      wr(4'h3, 8'h00);
      chk("periph_clk_en_o", 16'h0C00, periph_clk_en_o);
      wr(4'h4, 8'hF3);
      rd(4'h4);
      chk("gate2 reg", 16'h0000, 16'(rd_data));
      wr(4'h4, 8'hFF);
      wr(4'h3, 8'hFB);
      chk("periph_clk_en_o", 16'h0CFB, periph_clk_en_o);
      rd(4'hF);
      chk("unmapped reg", 16'h0000, 16'(rd_data));
      wr(4'h7, 8'h01);
      chk("core_clk_en_o", 16'h0000, 16'(core_clk_en_o));
      wr(4'h7, 8'h00);
      chk("core_clk_en_o", 16'h0001, 16'(core_clk_en_o));
      wr(4'h5, 8'h07);
      cyc(2);
      chk("rc_trim_o", 16'h0047, 16'(rc_trim_o));
      wr(4'h5, 8'h0F);
      cyc(2);
      chk("rc_trim_o", 16'h0039, 16'(rc_trim_o));
      @(posedge ref_clk_i);
      opt_byte <= 8'h01;
      opt_inv <= 8'hFE;
      wr(4'h5, 8'h07);
      cyc(2);
      chk("rc_trim_o", 16'h0043, 16'(rc_trim_o));
      wr(4'h9, 8'h02);
      wr(4'h0, 8'h02);
      cyc(20);
      chk("sys_src_o", 16'h0000, 16'(sys_src_o));
      @(posedge ref_clk_i);
      ready_req <= 4'hF;
      wait_src(SRC_XTAL);
      chk("src_en_o", 16'h0004, 16'(src_en_o));
      cyc(3);
      chk("irq_o", 16'h0001, 16'(irq_o));
      wr(4'h8, 8'h02);
      chk("irq_o", 16'h0000, 16'(irq_o));
      @(posedge ref_clk_i);
      opt_byte <= 8'h08;
      opt_inv <= 8'hFF;
      wr(4'h0, 8'h01);
      rd(4'h0);
      chk("src req reg", 16'h0002, 16'(rd_data));
      @(posedge ref_clk_i);
      opt_inv <= 8'hF7;
      wr(4'h0, 8'h01);
      wait_src(SRC_SLOW_RC);
      wr(4'h0, 8'h03);
      wait_src(SRC_EXT_IN);
      wr(4'h0, 8'h02);
      wait_src(SRC_XTAL);
      wr(4'h6, 8'h05);
      cyc(2);
      count_out(8);
      wr(4'h6, 8'h01);
      cyc(2);
      count_out(16);
      wr(4'h6, 8'h00);
      cyc(2);
      count_out(0);
      wr(4'h2, 8'h01);
      @(posedge ref_clk_i);
      halt_i <= 1'b1;
      cyc(3);
      chk("core_clk_en_o", 16'h0000, 16'(core_clk_en_o));
      chk("slow_rc_en_o", 16'h0001, 16'(slow_rc_en_o));
      @(posedge ref_clk_i);
      halt_i <= 1'b0;
      cyc(6);
      chk("sys_src_o", 16'h0000, 16'(sys_src_o));
      chk("sys_div_o", 16'h0003, 16'(sys_div_o));
      cyc(100);
      chk("sys_src_o", 16'h0000, 16'(sys_src_o));
      wait_src(SRC_XTAL);
      chk("sys_div_o", 16'h0001, 16'(sys_div_o));
      chk("core_clk_en_o", 16'h0001, 16'(core_clk_en_o));
      wr(4'h8, 8'h03);
      wr(4'h9, 8'h01);
      wr(4'hA, 8'h01);
      cyc(50);
      chk("irq_o", 16'h0000, 16'(irq_o));
      @(posedge ref_clk_i);
      run_en <= 4'hB;
      wait_src(SRC_FAST_RC);
      chk("irq_o", 16'h0001, 16'(irq_o));
      chk("sys_div_o", 16'h0003, 16'(sys_div_o));
      cyc(50);
      rd(4'h8);
      chk("fail status", 16'h0001, 16'(rd_data[0]));
      wr(4'h8, 8'h01);
      chk("irq_o", 16'h0000, 16'(irq_o));
      end_sim();
   end
endmodule : test_scc_clock_ctrl
